// ==== core/dcs_defines.svh ====
// Offsets, field positions, reset values and timing for the converter control
// Assumes a 12-bit APB byte address and 32-bit data words
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// Register byte offsets
`define DCS_OFF_CTRL_FIRST 12'h000
`define DCS_OFF_CTRL_SECOND 12'h004
`define DCS_OFF_ROUTE_GLOBAL 12'h008
`define DCS_OFF_ROUTE_LOCAL 12'h00C
`define DCS_OFF_ROUTE_MUXBUS 12'h010
`define DCS_OFF_UPDATE_GATE 12'h014
`define DCS_OFF_CODE 12'h018
`define DCS_OFF_TRIM 12'h01C
`define DCS_OFF_STATUS 12'h020

// First control register fields
`define DCS_CF_MODE 4
`define DCS_CF_RANGE_HI 3
`define DCS_CF_RANGE_LO 2

// Second control register fields
`define DCS_CS_SRC 5
`define DCS_CS_PLDIR 3
`define DCS_CS_SINK 2
`define DCS_CS_PORT 1

// Update gate register fields and strobe source codes
`define DCS_UG_EN 3
`define DCS_UG_SEL_HI 2
`define DCS_UG_SEL_LO 0
`define DCS_STB_BUS 3'h0
`define DCS_STB_ACLK 3'h1
`define DCS_STB_PL 3'h2

// Status register fields
`define DCS_ST_CODE_HI 7
`define DCS_ST_NEMPTY 8
`define DCS_ST_FULL 9

// Reset values
`define DCS_RST_BYTE 8'h00
`define DCS_RST_WORD 32'h0000_0000

// Analog clock strobe period and core clock period
`define DCS_ACLK_PERIOD_NS 100
`define DCS_CLK_PERIOD_PS 4000
`define DCS_ACLK_CYCLES ((`DCS_ACLK_PERIOD_NS * 1000) / `DCS_CLK_PERIOD_PS)

// Code FIFO shape
`define DCS_FIFO_DEPTH 8
`define DCS_CODE_W 8

`endif

// ==== core/dcs_pkg.sv ====
// Types shared by the converter control modules
// Assumes dcs_defines.svh holds all numeric constants
package dcs_pkg;
  // Register selected by an APB address
  typedef enum logic [3:0] {
    DCS_R_CTRL_FIRST,
    DCS_R_CTRL_SECOND,
    DCS_R_ROUTE_GLOBAL,
    DCS_R_ROUTE_LOCAL,
    DCS_R_ROUTE_MUXBUS,
    DCS_R_UPDATE_GATE,
    DCS_R_CODE,
    DCS_R_TRIM,
    DCS_R_STATUS,
    DCS_R_NONE
  } dcs_reg_t;

  typedef logic [7:0] dcs_byte_t;
endpackage

// ==== core/dcs_stream_if.sv ====
// Valid/ready word stream between the control core and its code FIFO
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface dcs_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ==== core/dcs_fifo.sv ====
// Code FIFO with valid/ready on both sides and a registered write ready
// Assumes an active-low reset with synchronised release from the top module
`timescale 1ns/1ps
module dcs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,      // Core clock
  input wire logic rst_b_i,    // Synchronised reset, active low
  dcs_stream_if.snk wr,        // Filling side
  dcs_stream_if.src rd,        // Draining side
  output logic full_o          // Full flag
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [CW-1:0] count, next_count;
  logic in_rdy, next_in_rdy;
  logic push, pop;

  // Handshakes and flags
  assign push = wr.valid & in_rdy;
  assign pop = rd.ready & (count != '0);
  assign wr.ready = in_rdy;
  assign rd.valid = (count != '0);
  assign rd.data = mem[rptr];
  assign full_o = ~in_rdy;

  // Pointer and count update, ready follows next count
  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (push) begin
      next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : AW'(wptr + 1'b1);
    end
    if (pop) begin
      next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : AW'(rptr + 1'b1);
    end
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
    next_in_rdy = (next_count != CW'(DEPTH));
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_rdy <= 1'b1;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      in_rdy <= next_in_rdy;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= wr.data;
    end
  end
endmodule

// ==== core/dcs_top.sv ====
// Digital control of an 8-bit current/voltage output converter
// Assumes an APB master on core_clk_i; analog blocks sit outside
//
// Overview of operation
// - Code from register or logic lines, bit-selected
// - Single shared converter bus; driver arbitrates
// - Output changes only on strobe when gated
// - Three-bit field picks the strobe source
// - Mode bit picks current or voltage output
// - Current mode: range field picks three scales
// - Voltage mode: range field picks two spans
// - Linear steps of full scale over 256
// - Register bit picks source or sink current
// - Logic input may steer source/sink instead
// - Trim byte adjusts mirror gain separately
// - Separate route muxes per output mode
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "dcs_defines.svh"
module dcs_top #(
  parameter int FIFO_DEPTH = `DCS_FIFO_DEPTH,
  parameter int ACLK_CYCLES = `DCS_ACLK_CYCLES
) (
  input wire logic core_clk_i,              // Core clock, 250 MHz
  input wire logic rst_b_i,                 // Async reset, active low
  input wire logic [11:0] paddr_i,          // APB address
  input wire logic psel_i,                  // APB select
  input wire logic penable_i,               // APB enable
  input wire logic pwrite_i,                // APB direction
  input wire logic [31:0] pwdata_i,         // APB write data
  output logic [31:0] prdata_o,             // APB read data
  output logic pready_o,                    // APB ready
  output logic pslverr_o,                   // APB error, unmapped
  input wire dcs_pkg::dcs_byte_t pl_code_i, // Logic-array code lines
  input wire logic pl_code_valid_i,         // Code lines valid
  input wire logic pl_bus_sel_i,            // Shared bus granted here
  output logic pl_code_ready_o,             // Code FIFO can take
  input wire logic pl_strobe_i,             // Logic-array strobe
  input wire logic pl_sink_i,               // Logic-array sink select
  output dcs_pkg::dcs_byte_t conv_code_o,   // Applied code
  output dcs_pkg::dcs_byte_t conv_trim_o,   // Mirror gain trim
  output logic current_mode_o,              // 1 current, 0 voltage
  output logic [1:0] range_o,               // Range field
  output logic sink_o,                      // Current sink selected
  output dcs_pkg::dcs_byte_t route_volt_global_o, // Voltage to globals
  output dcs_pkg::dcs_byte_t route_volt_local_o,  // Voltage to local bus
  output dcs_pkg::dcs_byte_t route_volt_mux_o,    // Voltage to mux bus
  output dcs_pkg::dcs_byte_t route_cur_global_o,  // Current to globals
  output dcs_pkg::dcs_byte_t route_cur_mux_o,     // Current to mux bus
  output logic route_cur_port_o             // Current to its port
);
  import dcs_pkg::*;

  localparam int AC_W = $clog2(ACLK_CYCLES + 1);

  // Address decode, used by access and read paths
  function automatic dcs_reg_t reg_decode(input logic [11:0] a);
    dcs_reg_t r;
    if (a == `DCS_OFF_CTRL_FIRST) r = DCS_R_CTRL_FIRST;
    else if (a == `DCS_OFF_CTRL_SECOND) r = DCS_R_CTRL_SECOND;
    else if (a == `DCS_OFF_ROUTE_GLOBAL) r = DCS_R_ROUTE_GLOBAL;
    else if (a == `DCS_OFF_ROUTE_LOCAL) r = DCS_R_ROUTE_LOCAL;
    else if (a == `DCS_OFF_ROUTE_MUXBUS) r = DCS_R_ROUTE_MUXBUS;
    else if (a == `DCS_OFF_UPDATE_GATE) r = DCS_R_UPDATE_GATE;
    else if (a == `DCS_OFF_CODE) r = DCS_R_CODE;
    else if (a == `DCS_OFF_TRIM) r = DCS_R_TRIM;
    else if (a == `DCS_OFF_STATUS) r = DCS_R_STATUS;
    else r = DCS_R_NONE;
    return r;
  endfunction

  // Reset release through two flops
  logic rst_m, rst_s;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  // Register state
  dcs_byte_t ctrl_first, ctrl_second, route_global, route_local;
  dcs_byte_t route_muxbus, update_gate, code_reg, trim_reg;
  dcs_byte_t next_ctrl_first, next_ctrl_second, next_route_global;
  dcs_byte_t next_route_local, next_route_muxbus, next_update_gate;
  dcs_byte_t next_code_reg, next_trim_reg;

  // Bus slave state
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  dcs_reg_t sel;
  logic commit, commit_wr, src_pl, fifo_full, can_go;

  // FIFO link
  dcs_stream_if #(.W(`DCS_CODE_W)) in_s ();
  dcs_stream_if #(.W(`DCS_CODE_W)) out_s ();

  dcs_fifo #(.W(`DCS_CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(core_clk_i),
    .rst_b_i(rst_s),
    .wr(in_s),
    .rd(out_s),
    .full_o(fifo_full)
  );

  // Access decode and completion
  assign sel = reg_decode(paddr_i);
  assign src_pl = ctrl_second[`DCS_CS_SRC];
  assign commit = psel_i & penable_i & pready_o;
  assign commit_wr = commit & pwrite_i;
  // A code write with the register source must wait for FIFO room, stalling the bus
  assign can_go = ~(pwrite_i & (sel == DCS_R_CODE) & ~src_pl & fifo_full);

  // FIFO filling: register writes or granted logic lines
  always_comb begin
    if (src_pl) begin
      in_s.data = pl_code_i;
      in_s.valid = pl_code_valid_i & pl_bus_sel_i;
    end else begin
      in_s.data = pwdata_i[`DCS_CODE_W-1:0];
      in_s.valid = commit_wr & (sel == DCS_R_CODE);
    end
  end
  assign pl_code_ready_o = in_s.ready;

  // Bus answer: one wait state, longer for a register-source code write while the FIFO is full
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata_o;
    if (psel_i && penable_i && !pready_o && can_go) begin
      next_pready = 1'b1;
      next_pslverr = (sel == DCS_R_NONE);
      next_prdata = `DCS_RST_WORD;
      if (!pwrite_i) begin
        if (sel == DCS_R_CTRL_FIRST) next_prdata[7:0] = ctrl_first;
        else if (sel == DCS_R_CTRL_SECOND) next_prdata[7:0] = ctrl_second;
        else if (sel == DCS_R_ROUTE_GLOBAL) next_prdata[7:0] = route_global;
        else if (sel == DCS_R_ROUTE_LOCAL) next_prdata[7:0] = route_local;
        else if (sel == DCS_R_ROUTE_MUXBUS) next_prdata[7:0] = route_muxbus;
        else if (sel == DCS_R_UPDATE_GATE) next_prdata[7:0] = update_gate;
        else if (sel == DCS_R_CODE) next_prdata[7:0] = code_reg;
        else if (sel == DCS_R_TRIM) next_prdata[7:0] = trim_reg;
        else if (sel == DCS_R_STATUS) begin
          next_prdata[`DCS_ST_CODE_HI:0] = conv_code_o;
          next_prdata[`DCS_ST_NEMPTY] = out_s.valid;
          next_prdata[`DCS_ST_FULL] = fifo_full;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= `DCS_RST_WORD;
    end else begin
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o <= next_prdata;
    end
  end

  // Register writes take effect at the completing edge
  always_comb begin
    next_ctrl_first = ctrl_first;
    next_ctrl_second = ctrl_second;
    next_route_global = route_global;
    next_route_local = route_local;
    next_route_muxbus = route_muxbus;
    next_update_gate = update_gate;
    next_code_reg = code_reg;
    next_trim_reg = trim_reg;
    if (commit_wr) begin
      if (sel == DCS_R_CTRL_FIRST) next_ctrl_first = pwdata_i[7:0];
      else if (sel == DCS_R_CTRL_SECOND) next_ctrl_second = pwdata_i[7:0];
      else if (sel == DCS_R_ROUTE_GLOBAL) next_route_global = pwdata_i[7:0];
      else if (sel == DCS_R_ROUTE_LOCAL) next_route_local = pwdata_i[7:0];
      else if (sel == DCS_R_ROUTE_MUXBUS) next_route_muxbus = pwdata_i[7:0];
      else if (sel == DCS_R_UPDATE_GATE) next_update_gate = pwdata_i[7:0];
      else if (sel == DCS_R_CODE) next_code_reg = pwdata_i[7:0];
      else if (sel == DCS_R_TRIM) next_trim_reg = pwdata_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      ctrl_first <= `DCS_RST_BYTE;
      ctrl_second <= `DCS_RST_BYTE;
      route_global <= `DCS_RST_BYTE;
      route_local <= `DCS_RST_BYTE;
      route_muxbus <= `DCS_RST_BYTE;
      update_gate <= `DCS_RST_BYTE;
      code_reg <= `DCS_RST_BYTE;
      trim_reg <= `DCS_RST_BYTE;
    end else begin
      ctrl_first <= next_ctrl_first;
      ctrl_second <= next_ctrl_second;
      route_global <= next_route_global;
      route_local <= next_route_local;
      route_muxbus <= next_route_muxbus;
      update_gate <= next_update_gate;
      code_reg <= next_code_reg;
      trim_reg <= next_trim_reg;
    end
  end

  // Strobe sources: delayed bus write, analog clock divider, logic edge
  logic [AC_W-1:0] aclk_cnt, next_aclk_cnt;
  logic aclk_stb, next_aclk_stb, bus_stb, next_bus_stb;
  logic pl_stb_q, strobe_evt;

  always_comb begin
    next_aclk_stb = 1'b0;
    next_aclk_cnt = AC_W'(aclk_cnt + 1'b1);
    if (aclk_cnt == AC_W'(ACLK_CYCLES - 1)) begin
      next_aclk_cnt = '0;
      next_aclk_stb = 1'b1;
    end
    // Word is visible in the FIFO one cycle after its write
    next_bus_stb = commit_wr & (sel == DCS_R_CODE) & ~src_pl;
  end

  always_ff @(posedge core_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      aclk_cnt <= '0;
      aclk_stb <= 1'b0;
      bus_stb <= 1'b0;
      pl_stb_q <= 1'b0;
    end else begin
      aclk_cnt <= next_aclk_cnt;
      aclk_stb <= next_aclk_stb;
      bus_stb <= next_bus_stb;
      pl_stb_q <= pl_strobe_i;
    end
  end

  // Strobe source select
  always_comb begin
    case (update_gate[`DCS_UG_SEL_HI:`DCS_UG_SEL_LO])
      `DCS_STB_BUS: strobe_evt = bus_stb;
      `DCS_STB_ACLK: strobe_evt = aclk_stb;
      `DCS_STB_PL: strobe_evt = pl_strobe_i & ~pl_stb_q;
      default: strobe_evt = 1'b0;
    endcase
  end

  // Drain on strobe when gated, at once when not
  assign out_s.ready = ~update_gate[`DCS_UG_EN] | strobe_evt;

  // Applied code and analog controls
  dcs_byte_t next_code_out, next_rv_g, next_rv_l, next_rv_m;
  dcs_byte_t next_rc_g, next_rc_m;
  logic next_mode, next_sink, next_port, cur;

  assign cur = ctrl_first[`DCS_CF_MODE];
  always_comb begin
    next_code_out = conv_code_o;
    if (out_s.valid && out_s.ready) begin
      next_code_out = out_s.data;
    end
    next_mode = cur;
    if (ctrl_second[`DCS_CS_PLDIR]) begin
      next_sink = cur & pl_sink_i;
    end else begin
      next_sink = cur & ctrl_second[`DCS_CS_SINK];
    end
    next_rv_g = cur ? `DCS_RST_BYTE : route_global;
    next_rv_l = cur ? `DCS_RST_BYTE : route_local;
    next_rv_m = cur ? `DCS_RST_BYTE : route_muxbus;
    next_rc_g = cur ? route_global : `DCS_RST_BYTE;
    next_rc_m = cur ? route_muxbus : `DCS_RST_BYTE;
    next_port = cur & ctrl_second[`DCS_CS_PORT];
  end

  always_ff @(posedge core_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      conv_code_o <= `DCS_RST_BYTE;
      conv_trim_o <= `DCS_RST_BYTE;
      current_mode_o <= 1'b0;
      range_o <= 2'h0;
      sink_o <= 1'b0;
      route_volt_global_o <= `DCS_RST_BYTE;
      route_volt_local_o <= `DCS_RST_BYTE;
      route_volt_mux_o <= `DCS_RST_BYTE;
      route_cur_global_o <= `DCS_RST_BYTE;
      route_cur_mux_o <= `DCS_RST_BYTE;
      route_cur_port_o <= 1'b0;
    end else begin
      conv_code_o <= next_code_out;
      conv_trim_o <= trim_reg;
      current_mode_o <= next_mode;
      // Same field, scale read per mode
      range_o <= ctrl_first[`DCS_CF_RANGE_HI:`DCS_CF_RANGE_LO];
      sink_o <= next_sink;
      route_volt_global_o <= next_rv_g;
      route_volt_local_o <= next_rv_l;
      route_volt_mux_o <= next_rv_m;
      route_cur_global_o <= next_rc_g;
      route_cur_mux_o <= next_rc_m;
      route_cur_port_o <= next_port;
    end
  end
endmodule

// ==== bench/dcs_top_props.sv ====
// Concurrent checks on the converter control top-level ports
// Assumes it is bound onto dcs_top and sees only its ports
`timescale 1ns/1ps
module dcs_top_props (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [31:0] prdata_o, // APB read data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic current_mode_o, // Current mode
  input wire logic [1:0] range_o, // Range field
  input wire logic sink_o, // Sink select
  input wire dcs_pkg::dcs_byte_t route_volt_global_o, // Voltage globals
  input wire dcs_pkg::dcs_byte_t route_volt_mux_o, // Voltage mux bus
  input wire dcs_pkg::dcs_byte_t route_cur_global_o, // Current globals
  input wire logic route_cur_port_o // Current port
);
  import dcs_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Bus answer shape
  property p_rdy_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready held");
  property p_rdy_access;
    pready_o |-> psel_i && penable_i && $past(penable_i);
  endproperty
  a_rdy_access: assert property (p_rdy_access)
    else $error("early ready");
  property p_err_zero;
    pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error read data");
  property p_upper_zero;
    pready_o && !pwrite_i |-> prdata_o[31:10] == 22'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper bits");

  // Mode gating of routes and direction, mode changes only after a write, reset values
  property p_volt_gate;
    current_mode_o |-> (route_volt_global_o | route_volt_mux_o) == 8'h00;
  endproperty
  a_volt_gate: assert property (p_volt_gate)
    else $error("volt route");
  property p_cur_gate;
    !current_mode_o |-> route_cur_global_o == 8'h00 && !route_cur_port_o
      && !sink_o;
  endproperty
  a_cur_gate: assert property (p_cur_gate)
    else $error("cur route");
  property p_mode_cause;
    !$stable({current_mode_o, range_o}) |->
      $past(pready_o && pwrite_i) || $past(pready_o && pwrite_i, 2);
  endproperty
  a_mode_cause: assert property (p_mode_cause)
    else $error("mode moved");
  property p_rst_clear;
    $rose(rst_b_i) |-> !current_mode_o && range_o == 2'h0 && !pready_o;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset value");
endmodule
bind dcs_top dcs_top_props i_props (.*);

// ==== bench/dcs_pl_model.sv ====
// Logic-array model: codes over the shared bus, strobes, sink select
// Assumes one converter, so the shared bus grant is held only per code
`timescale 1ns/1ps
module dcs_pl_model (
  input wire logic clk_i, // Core clock
  input wire logic ready_i, // Code FIFO can take
  output dcs_pkg::dcs_byte_t code_o, // Code lines
  output logic valid_o, // Code valid
  output logic sel_o, // Bus grant
  output logic strobe_o, // Update strobe
  output logic sink_o // Sink select
);
  import dcs_pkg::*;
  // 32 cycles apart keeps current-mode updates under 8 million/s
  int gap = 31;
  // Idle lines
  initial begin
    code_o = 8'h5A;
    valid_o = 1'b0;
    sel_o = 1'b0;
    strobe_o = 1'b0;
    sink_o = 1'b0;
  end
  // One code per call, spaced by gap + 1 cycles
  task automatic send(input dcs_byte_t b);
    repeat (gap + 1) @(posedge clk_i);
    code_o <= b;
    valid_o <= 1'b1;
    sel_o <= 1'b1;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    valid_o <= 1'b0;
    sel_o <= 1'b0;
    code_o <= ~b;
  endtask
  // One strobe pulse
  task automatic pulse();
    @(posedge clk_i);
    strobe_o <= 1'b1;
    @(posedge clk_i);
    strobe_o <= 1'b0;
  endtask
  // Sink select level
  task automatic set_sink(input logic v);
    @(posedge clk_i);
    sink_o <= v;
  endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the converter control top level
// Assumes the logic-array model and the bound checker alongside
`timescale 1ns/1ps
`include "dcs_defines.svh"
module tb;
  import dcs_pkg::*;
  localparam int ACLK = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, rdy, vld, sel, stb, psnk, mode, sink, port;
  logic [1:0] rng;
  dcs_byte_t plc, code, trim, vg, vl, vm, cg, cm;
  dcs_byte_t rg [0:7];
  dcs_byte_t q [$];
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hFE7A13A4;

  dcs_top #(.ACLK_CYCLES(ACLK)) i_dcs_top (
    .core_clk_i(clk), .rst_b_i(rst_b), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .pl_code_i(plc), .pl_code_valid_i(vld), .pl_bus_sel_i(sel),
    .pl_code_ready_o(rdy), .pl_strobe_i(stb), .pl_sink_i(psnk),
    .conv_code_o(code), .conv_trim_o(trim), .current_mode_o(mode),
    .range_o(rng), .sink_o(sink), .route_volt_global_o(vg),
    .route_volt_local_o(vl), .route_volt_mux_o(vm),
    .route_cur_global_o(cg), .route_cur_mux_o(cm), .route_cur_port_o(port)
  );
  dcs_pl_model i_dcs_pl_model (.clk_i(clk), .ready_i(rdy), .code_o(plc),
    .valid_o(vld), .sel_o(sel), .strobe_o(stb), .sink_o(psnk));

  // Core clock
  always #2 clk = ~clk;
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; the register model follows writes
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a < 12'h020) rg[a[4:2]] = d[7:0];
  endtask
  task automatic code_is(input dcs_byte_t v);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("code", 32'(code), 32'(v));
  endtask
  task automatic check_outs();
    logic m, s;
    logic [31:0] ev, ec;
    m = rg[0][4];
    s = m & (rg[1][3] ? psnk : rg[1][2]);
    ev = m ? 32'h0 : {rg[2], rg[3], rg[4], 8'h00};
    ec = m ? {rg[2], rg[4], 15'h0, rg[1][1]} : 32'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("mode", 32'(mode), 32'(m));
    chk("range", 32'(rng), 32'(rg[0][3:2]));
    chk("sink", 32'(sink), 32'(s));
    chk("trim", 32'(trim), 32'(rg[7]));
    chk("vroute", {vg, vl, vm, 8'h00}, ev);
    chk("croute", {cg, cm, 15'h0, port}, ec);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a <= 36; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk("rst", rd, 32'h0);
      chk("err", 32'(er), 32'(a == 36));
    end
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      i_dcs_pl_model.set_sink(seed[0]);
      for (int r = 0; r < 8; r++) begin
        seed = lfsr(seed);
        seed[4] = (r == 0) ? i[0] : seed[4];
        seed[5] = (r == 1) ? 1'b0 : seed[5];
        if (r < 5 || r == 7) begin
          apb(1'b1, 12'(r * 4), seed);
          apb(1'b0, 12'(r * 4), 32'h0);
          chk("rdback", rd, 32'(rg[r]));
        end
      end
      check_outs();
    end
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'h0);
    apb(1'b1, `DCS_OFF_CODE, 32'hA5);
    code_is(8'hA5);
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'h8);
    apb(1'b1, `DCS_OFF_CODE, 32'h3C);
    code_is(8'h3C);
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'hB);
    apb(1'b1, `DCS_OFF_CODE, 32'h66);
    code_is(8'h3C);
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'h8);
    apb(1'b1, `DCS_OFF_CODE, 32'h77);
    code_is(8'h66);
    apb(1'b0, `DCS_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h166);
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'h0);
    code_is(8'h77);
    // Logic-array codes wait for its strobe; FIFO fills to the brim
    apb(1'b1, `DCS_OFF_CTRL_SECOND, 32'h20);
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'hA);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      i_dcs_pl_model.send(seed[7:0]);
    end
    @(negedge clk);
    chk("ready", 32'(rdy), 32'h0);
    apb(1'b1, `DCS_OFF_CODE, 32'h11);
    apb(1'b0, `DCS_OFF_STATUS, 32'h0);
    chk("full", rd, 32'h377);
    while (q.size() > 0) begin
      i_dcs_pl_model.pulse();
      code_is(q.pop_front());
    end
    apb(1'b0, `DCS_OFF_STATUS, 32'h0);
    chk("empty", 32'(rd[9:8]), 32'h0);
    // Divider strobe with a slow sender, then ungated logic codes
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'h9);
    i_dcs_pl_model.gap = 40;
    i_dcs_pl_model.send(8'h40);
    i_dcs_pl_model.send(8'h41);
    repeat (4 * ACLK) @(posedge clk);
    code_is(8'h41);
    apb(1'b1, `DCS_OFF_UPDATE_GATE, 32'h0);
    i_dcs_pl_model.send(8'hC3);
    code_is(8'hC3);
    // Low converter of a summed twelve-bit pair: low nibble in the middle
    seed = lfsr(seed);
    i_dcs_pl_model.send({2'h0, seed[3:0], 2'h0});
    code_is({2'h0, seed[3:0], 2'h0});
    wrap_up();
  end
endmodule
